// ==== common/acs_map.svh ====
// Register map, fields, reset values and timing of the clock status bank.
// Definitions only.
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH

// Register indices; the bus byte address is four times the index.
`define ACS_IDX_CLK_STATUS 8'h00
`define ACS_IDX_REVISION 8'h01
`define ACS_IDX_ERR_FLAGS 8'h02
`define ACS_IDX_FILTER_CTRL 8'h03
`define ACS_IDX_SERIAL_FMT 8'h04
`define ACS_IDX_SHUTDOWN 8'h05
`define ACS_IDX_VOLUME_CFG 8'h0E
`define ACS_BYTE_ADDR(idx) ((idx) << 2)

// Clock status fields.
`define ACS_RATE_MSB 7
`define ACS_RATE_LSB 5
`define ACS_RATIO_MSB 4
`define ACS_RATIO_LSB 2

// Error flag positions.
`define ACS_ERR_MCLK_BIT 7
`define ACS_ERR_PLL_BIT 6
`define ACS_ERR_SCLK_BIT 5
`define ACS_ERR_LRCLK_BIT 4
`define ACS_ERR_SLIP_BIT 3
`define ACS_ERR_OVERCUR_BIT 1
`define ACS_ERR_USED_MASK 8'hFA

// Control fields.
`define ACS_DCBLOCK_BIT 7
`define ACS_HARD_UNMUTE_BIT 5
`define ACS_DEEMPH_MSB 1
`define ACS_DEEMPH_LSB 0
`define ACS_FMT_MSB 3
`define ACS_FMT_LSB 0
`define ACS_SHUTDOWN_BIT 6
`define ACS_SLEW_MSB 2
`define ACS_SLEW_LSB 0

// Reset values.
`define ACS_RST_CLK_STATUS 8'h6C
`define ACS_RST_ERR_FLAGS 8'h00
`define ACS_RST_FILTER_CTRL 8'hA0
`define ACS_RST_SERIAL_FMT 4'h5
`define ACS_RST_SHUTDOWN 1'b1
`define ACS_RST_SLEW 3'h1

// System clock rate and sample-rate class boundaries.
`define ACS_SYS_CLK_HZ 100000000
`define ACS_EDGE_8K_11K_HZ 10000
`define ACS_EDGE_11K_16K_HZ 14000
`define ACS_EDGE_16K_22K_HZ 20000
`define ACS_EDGE_22K_32K_HZ 28000
`define ACS_EDGE_32K_44K_HZ 38000
`define ACS_FRAME_LOSS_US 250

// Master clocks per frame: boundaries between ratios.
`define ACS_RATIO_EDGE_128 96
`define ACS_RATIO_EDGE_192 160
`define ACS_RATIO_EDGE_256 224
`define ACS_RATIO_EDGE_384 320
`define ACS_RATIO_EDGE_512 448

// Bit clocks per frame and tolerances.
`define ACS_BCLK_48 48
`define ACS_COUNT_TOL 1
`define ACS_PERIOD_TOL 4
`define ACS_RECOVER_FRAMES 4

`endif

// ==== common/acs_pkg.sv ====
// Types shared by the audio clock status and control bank.
// Assumes the map header is on the include path.
package acs_pkg;
    `include "acs_map.svh"

    typedef logic [2:0] rate_code_t;
    typedef logic [2:0] ratio_code_t;
    typedef logic [1:0] deemph_t;
    typedef logic [3:0] serial_fmt_t;

    typedef enum logic [2:0] {
        REC_RUN   = 3'b001,
        REC_MUTED = 3'b010,
        REC_RAMP  = 3'b100
    } recover_e;
endpackage

// ==== src/clock_edge_meter.sv ====
// Synchronises one audio clock pin, finds its rising edges, counts them per frame.
// Pin toggles slower than a third of sys_clk; frameRise is a one-cycle pulse.
`timescale 1ns/10ps
module clock_edge_meter #(
    parameter int CNT_W = 10
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // Pin and frame marker
    input  wire logic        pinIn,
    input  wire logic        frameRise,
    // Results
    output logic             risePulse,
    output logic [CNT_W-1:0] perFrame_ff
);
    logic             sync1_ff;
    logic             sync2_ff;
    logic             prev_ff;
    logic [CNT_W-1:0] count_ff;
    logic [CNT_W-1:0] nxt_count;
    wire              countFull = &count_ff;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff  <= 1'b0;
        end else begin
            sync1_ff <= pinIn;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    assign risePulse = sync2_ff & ~prev_ff;

    // The count saturates so a stopped frame clock cannot wrap it into a plausible value.
    always_comb begin
        nxt_count = count_ff;
        if (frameRise)
            nxt_count = {{(CNT_W-1){1'b0}}, risePulse};
        else if (risePulse && !countFull)
            nxt_count = count_ff + 1'b1;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            count_ff    <= '0;
            perFrame_ff <= '0;
        end else begin
            count_ff <= nxt_count;
            if (frameRise)
                perFrame_ff <= count_ff;
        end
    end
endmodule

// ==== src/audio_clock_status_ctl.sv ====
// Clock status, sticky error flags and control registers of an audio front end, on APB.
// Clock and fault pins are asynchronous; the APB master runs on sys_clk.
//
// Functional notes
// R1 - Sample rate and clock ratio are detected in hardware and read back only.
// R2 - Rate field 7:5: 000 32k, 011 48k, 100 16k, 101 24k, 110 8k, 111 12k.
// R3 - Ratio field 4:2: codes 000..101 mean 64,128,192,256,384,512 times rate.
// R4 - Source uses 64x only at 48k, 192x at 32-48k, never 256x at 8k.
// R5 - Bit clock 32 or 64 per frame always; 48 only with 192x or 384x.
// R6 - Identification register returns fixed seven-bit revision code, bit 7 reserved.
// R7 - Error flags are sticky; only a host write of zero clears them.
// R8 - Host clears the error register then reads back to find ongoing errors.
// R9 - Error bits: 7 mclk, 6 pll, 5 bit clock, 4 frame clock, 3 slip, 1 overcurrent.
// R10 - Master clock error when master clocks per frame change.
// R11 - Bit clock error when bit clocks per frame change.
// R12 - Frame clock error when frame clock frequency changes.
// R13 - Frame slip when frame clock phase drifts against internal frame sync.
// R14 - Control bit 7 enables the DC-blocking filter, enabled by default.
// R15 - Bit 5 clear ramps unmute after clock error; set unmutes in one step.
// R16 - Bits 1:0 select de-emphasis: none, reserved, 44.1k, 48k.
// R17 - Four-bit serial format code selects nine formats; other codes reserved.
// R18 - Serial format resets to 24-bit I2S, code 0101.
// R19 - Shutdown bit 6 set holds all channels in hard mute; clear starts playback.
// R20 - Host avoids reserved registers and keeps reserved bits at documented values.
// R21 - Soft unmute ramp length is 512, 1024, 2048 or 256 steps by slew code.
// R22 - A flag set in the same cycle as its clear stays set.
`timescale 1ns/10ps
`include "acs_map.svh"
module audio_clock_status_ctl #(
    parameter logic [6:0] REVISION_CODE     = 7'h2A,  // Arbitrary value.
    parameter int         FRAME_LOSS_CYCLES = `ACS_FRAME_LOSS_US * (`ACS_SYS_CLK_HZ / 1000000)
) (
    // Clock and reset
    input  wire logic            sys_clk,
    input  wire logic            resetn,
    // APB slave
    input  wire logic [7:0]      paddr,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [31:0]     pwdata,
    output logic [31:0]          prdata,
    output logic                 pready,
    output logic                 pslverr,
    // Serial audio clock pins
    input  wire logic            mclkPin,
    input  wire logic            sclkPin,
    input  wire logic            lrclkPin,
    // Fault pins
    input  wire logic            pllUnlockPin,
    input  wire logic            overCurrentPin,
    // Controls to the audio path
    output logic                 dcBlockEn,
    output acs_pkg::deemph_t     deemphSel,
    output acs_pkg::serial_fmt_t serialFormat,
    output logic                 shutdownAll,
    output logic                 clockMute,
    output logic                 unmuteRamping,
    output logic [11:0]          unmuteStep,
    output acs_pkg::rate_code_t  sampleRate,
    output acs_pkg::ratio_code_t mclkRatio
);
    import acs_pkg::*;

    ////////////////////////
    // Pin synchronisers and per-frame measurement.

    logic        lrRise;
    logic        mclkRise;
    logic        sclkRise;
    logic [9:0]  mclkPerFrame;
    logic [6:0]  sclkPerFrame;
    logic [1:0]  faultSync1_ff;
    logic [1:0]  faultSync2_ff;

    clock_edge_meter #(.CNT_W(1)) u_lrclk (
        .sys_clk     (sys_clk),
        .resetn      (resetn),
        .pinIn       (lrclkPin),
        .frameRise   (1'b0),
        .risePulse   (lrRise),
        .perFrame_ff ()
    );

    clock_edge_meter #(.CNT_W(10)) u_mclk (
        .sys_clk     (sys_clk),
        .resetn      (resetn),
        .pinIn       (mclkPin),
        .frameRise   (lrRise),
        .risePulse   (mclkRise),
        .perFrame_ff (mclkPerFrame)
    );

    clock_edge_meter #(.CNT_W(7)) u_sclk (
        .sys_clk     (sys_clk),
        .resetn      (resetn),
        .pinIn       (sclkPin),
        .frameRise   (lrRise),
        .risePulse   (sclkRise),
        .perFrame_ff (sclkPerFrame)
    );

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            faultSync1_ff <= 2'b00;
            faultSync2_ff <= 2'b00;
        end else begin
            faultSync1_ff <= {pllUnlockPin, overCurrentPin};
            faultSync2_ff <= faultSync1_ff;
        end
    end

    ////////////////////////
    // Frame period in system clocks, internal frame sync and classification.

    logic [14:0] periodCnt_ff;
    logic [14:0] period_ff;
    logic [14:0] phase_ff;
    logic [9:0]  mclkLast_ff;
    logic [6:0]  sclkLast_ff;
    logic [1:0]  primed_ff;
    rate_code_t  rate_ff;
    ratio_code_t ratio_ff;

    function automatic logic differs(input logic [14:0] a, input logic [14:0] b, input logic [14:0] tol);
        differs = (a > b) ? ((a - b) > tol) : ((b - a) > tol);
    endfunction

    wire frameLost   = (periodCnt_ff == 15'(FRAME_LOSS_CYCLES));
    wire measured    = primed_ff[1];
    wire periodMoved = differs(periodCnt_ff, period_ff, 15'(`ACS_PERIOD_TOL));
    wire phaseWrap   = (phase_ff >= period_ff - 15'd1);

    // The internal frame sync wraps on the last period and restarts on each frame clock edge; a frame clock edge far from its wrap is a slip.
    wire phaseOff    = (phase_ff > 15'(`ACS_PERIOD_TOL)) && (phase_ff < period_ff - 15'(`ACS_PERIOD_TOL));

    // Nearest class to the measured frame period.
    wire rate_code_t nxt_rate =
        (periodCnt_ff > 15'(`ACS_SYS_CLK_HZ / `ACS_EDGE_8K_11K_HZ))  ? 3'b110 :
        (periodCnt_ff > 15'(`ACS_SYS_CLK_HZ / `ACS_EDGE_11K_16K_HZ)) ? 3'b111 :
        (periodCnt_ff > 15'(`ACS_SYS_CLK_HZ / `ACS_EDGE_16K_22K_HZ)) ? 3'b100 :
        (periodCnt_ff > 15'(`ACS_SYS_CLK_HZ / `ACS_EDGE_22K_32K_HZ)) ? 3'b101 :
        (periodCnt_ff > 15'(`ACS_SYS_CLK_HZ / `ACS_EDGE_32K_44K_HZ)) ? 3'b000 : 3'b011;  // [R2]

    // Nearest ratio to the master clock count per frame.
    wire ratio_code_t nxt_ratio =
        (mclkPerFrame < 10'(`ACS_RATIO_EDGE_128)) ? 3'b000 :
        (mclkPerFrame < 10'(`ACS_RATIO_EDGE_192)) ? 3'b001 :
        (mclkPerFrame < 10'(`ACS_RATIO_EDGE_256)) ? 3'b010 :
        (mclkPerFrame < 10'(`ACS_RATIO_EDGE_384)) ? 3'b011 :
        (mclkPerFrame < 10'(`ACS_RATIO_EDGE_512)) ? 3'b100 : 3'b101;  // [R3]

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            periodCnt_ff <= '0;
            period_ff    <= '0;
            primed_ff    <= 2'b00;
            rate_ff      <= 3'(`ACS_RST_CLK_STATUS >> `ACS_RATE_LSB);
        end else if (lrRise) begin
            periodCnt_ff <= 15'd1;
            period_ff    <= periodCnt_ff;
            primed_ff    <= {primed_ff[0], 1'b1};
            if (primed_ff[0])
                rate_ff <= nxt_rate;  // [R1]
        end else if (!frameLost) begin
            periodCnt_ff <= periodCnt_ff + 15'd1;
        end else begin
            primed_ff <= 2'b00;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn)
            phase_ff <= '0;
        else if (lrRise || phaseWrap)
            phase_ff <= '0;
        else
            phase_ff <= phase_ff + 15'd1;
    end

    // Counts are compared one cycle after the frame clock edge, once the meters have published them.
    logic lrRiseDly_ff;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            lrRiseDly_ff <= 1'b0;
            mclkLast_ff  <= '0;
            sclkLast_ff  <= '0;
            ratio_ff     <= 3'(`ACS_RST_CLK_STATUS >> `ACS_RATIO_LSB);
        end else begin
            lrRiseDly_ff <= lrRise;
            if (lrRiseDly_ff) begin
                mclkLast_ff <= mclkPerFrame;
                sclkLast_ff <= sclkPerFrame;
                if (measured)
                    ratio_ff <= nxt_ratio;  // [R1]
            end
        end
    end

    ////////////////////////
    // Error events.

    wire sclkIs48  = !differs(15'(sclkPerFrame), 15'(`ACS_BCLK_48), 15'(`ACS_COUNT_TOL));
    wire ratioFor48 = (nxt_ratio == 3'b010) || (nxt_ratio == 3'b100);
    wire checkNow  = lrRiseDly_ff && measured;

    wire mclkEvt  = checkNow && differs(15'(mclkPerFrame), 15'(mclkLast_ff), 15'(`ACS_COUNT_TOL));  // [R10]
    wire sclkEvt  = checkNow && (differs(15'(sclkPerFrame), 15'(sclkLast_ff), 15'(`ACS_COUNT_TOL))  // [R11]
                                 || (sclkIs48 && !ratioFor48));  // [R5]
    wire lrEvt    = (lrRise && measured && periodMoved) || (frameLost && primed_ff[0]);  // [R12]
    wire slipEvt  = lrRise && measured && !periodMoved && phaseOff;  // [R13]
    wire clkErrEvt = mclkEvt | sclkEvt | lrEvt | slipEvt;

    logic [7:0] errSet;
    always_comb begin
        errSet                       = 8'h00;
        errSet[`ACS_ERR_MCLK_BIT]    = mclkEvt;
        errSet[`ACS_ERR_PLL_BIT]     = faultSync2_ff[1];
        errSet[`ACS_ERR_SCLK_BIT]    = sclkEvt;
        errSet[`ACS_ERR_LRCLK_BIT]   = lrEvt;
        errSet[`ACS_ERR_SLIP_BIT]    = slipEvt;
        errSet[`ACS_ERR_OVERCUR_BIT] = faultSync2_ff[0];  // [R9]
    end

    ////////////////////////
    // APB register file.

    logic [7:0]  errFlags_ff;
    logic [7:0]  filterCtrl_ff;
    serial_fmt_t serialFmt_ff;
    logic        shutdown_ff;
    logic [2:0]  slew_ff;
    logic [31:0] prdata_ff;
    logic        pslverr_ff;

    wire setupPhase = psel && !penable;
    wire wrAccess   = psel && penable && pwrite;
    wire selStatus  = (paddr == `ACS_BYTE_ADDR(`ACS_IDX_CLK_STATUS));
    wire selRev     = (paddr == `ACS_BYTE_ADDR(`ACS_IDX_REVISION));
    wire selErr     = (paddr == `ACS_BYTE_ADDR(`ACS_IDX_ERR_FLAGS));
    wire selFilter  = (paddr == `ACS_BYTE_ADDR(`ACS_IDX_FILTER_CTRL));
    wire selFmt     = (paddr == `ACS_BYTE_ADDR(`ACS_IDX_SERIAL_FMT));
    wire selShut    = (paddr == `ACS_BYTE_ADDR(`ACS_IDX_SHUTDOWN));
    wire selSlew    = (paddr == `ACS_BYTE_ADDR(`ACS_IDX_VOLUME_CFG));
    wire mapped     = selStatus | selRev | selErr | selFilter | selFmt | selShut | selSlew;

    // Reserved bits are not stored, so they read back as zero whatever the host writes.
    wire [7:0] statusWord = {rate_ff, ratio_ff, 2'b00};  // [R1]
    wire [7:0] filterMask = 8'h00 | (8'h1 << `ACS_DCBLOCK_BIT) | (8'h1 << `ACS_HARD_UNMUTE_BIT) | 8'h03;

    wire [7:0] readByte =
        selStatus ? statusWord :
        selRev    ? {1'b0, REVISION_CODE} :  // [R6]
        selErr    ? errFlags_ff :
        selFilter ? filterCtrl_ff :
        selFmt    ? {4'h0, serialFmt_ff} :
        selShut   ? 8'(shutdown_ff) << `ACS_SHUTDOWN_BIT :
        selSlew   ? {5'h00, slew_ff} : 8'h00;

    // A written zero clears a flag; a set arriving in the same cycle wins.
    wire [7:0] errClearKeep = (wrAccess && selErr) ? pwdata[7:0] : 8'hFF;  // [R7]
    wire [7:0] nxt_errFlags = ((errFlags_ff & errClearKeep) | errSet) & `ACS_ERR_USED_MASK;  // [R22]

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            errFlags_ff   <= `ACS_RST_ERR_FLAGS;
            filterCtrl_ff <= `ACS_RST_FILTER_CTRL;  // [R14] [R15]
            serialFmt_ff  <= `ACS_RST_SERIAL_FMT;  // [R18]
            shutdown_ff   <= `ACS_RST_SHUTDOWN;
            slew_ff       <= `ACS_RST_SLEW;
        end else begin
            errFlags_ff <= nxt_errFlags;
            if (wrAccess && selFilter)
                filterCtrl_ff <= pwdata[7:0] & filterMask;  // [R16]
            if (wrAccess && selFmt)
                serialFmt_ff <= pwdata[`ACS_FMT_MSB:`ACS_FMT_LSB];  // [R17]
            if (wrAccess && selShut)
                shutdown_ff <= pwdata[`ACS_SHUTDOWN_BIT];  // [R19]
            if (wrAccess && selSlew)
                slew_ff <= pwdata[`ACS_SLEW_MSB:`ACS_SLEW_LSB];
        end
    end

    // Read data and error are latched in the setup cycle, so the access cycle answers from flip-flops.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            prdata_ff  <= '0;
            pslverr_ff <= 1'b0;
        end else if (setupPhase) begin
            prdata_ff  <= {24'h00_0000, readByte};
            pslverr_ff <= !mapped;
        end
    end

    assign pready  = psel && penable;
    assign prdata  = prdata_ff;
    assign pslverr = pslverr_ff && psel && penable;

    ////////////////////////
    // Mute on clock error and unmute on recovery.

    recover_e    rec_ff;
    recover_e    nxt_rec;
    logic [2:0]  stable_ff;
    logic [2:0]  nxt_stable;
    logic [11:0] step_ff;
    logic [11:0] nxt_step;
    logic [11:0] rampSteps;

    // Slew codes with the top bit set are reserved and fall back to the default length.
    always_comb begin
        unique case (slew_ff)
            3'b000:  rampSteps = 12'd512;
            3'b010:  rampSteps = 12'd2048;
            3'b011:  rampSteps = 12'd256;
            default: rampSteps = 12'd1024;
        endcase  // [R21]
    end

    wire hardUnmute = filterCtrl_ff[`ACS_HARD_UNMUTE_BIT];
    wire recovered  = lrRise && (stable_ff == 3'(`ACS_RECOVER_FRAMES - 1));

    always_comb begin
        nxt_rec    = rec_ff;
        nxt_stable = stable_ff;
        nxt_step   = step_ff;
        unique case (rec_ff)
            REC_RUN: begin
                if (clkErrEvt) begin
                    nxt_rec    = REC_MUTED;
                    nxt_stable = '0;
                end
            end
            REC_MUTED: begin
                if (clkErrEvt) begin
                    nxt_stable = '0;
                end else if (recovered) begin
                    nxt_rec  = hardUnmute ? REC_RUN : REC_RAMP;  // [R15]
                    nxt_step = '0;
                end else if (lrRise) begin
                    nxt_stable = stable_ff + 3'd1;
                end
            end
            REC_RAMP: begin
                if (clkErrEvt) begin
                    nxt_rec    = REC_MUTED;
                    nxt_stable = '0;
                end else if (lrRise) begin
                    nxt_step = step_ff + 12'd1;
                    if (step_ff >= rampSteps - 12'd1)
                        nxt_rec = REC_RUN;  // [R21]
                end
            end
            default: begin
                nxt_rec = REC_MUTED;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rec_ff    <= REC_RUN;
            stable_ff <= '0;
            step_ff   <= '0;
        end else begin
            rec_ff    <= nxt_rec;
            stable_ff <= nxt_stable;
            step_ff   <= nxt_step;
        end
    end

    ////////////////////////
    // Control outputs.

    assign dcBlockEn     = filterCtrl_ff[`ACS_DCBLOCK_BIT];  // [R14]
    assign deemphSel     = filterCtrl_ff[`ACS_DEEMPH_MSB:`ACS_DEEMPH_LSB];  // [R16]
    assign serialFormat  = serialFmt_ff;  // [R17]
    assign shutdownAll   = shutdown_ff;  // [R19]
    assign clockMute     = (rec_ff == REC_MUTED);
    assign unmuteRamping = (rec_ff == REC_RAMP);
    assign unmuteStep    = step_ff;
    assign sampleRate    = rate_ff;
    assign mclkRatio     = ratio_ff;
endmodule

// ==== tb/acs_props.sv ====
// Concurrent checks on the APB side and control outputs of the status bank.
// Bound to the bank; sees only its ports.
`timescale 1ns/10ps
module acs_props (
    // Clock and reset
    input logic                 sys_clk,
    input logic                 resetn,
    // APB
    input logic [7:0]           paddr,
    input logic                 psel,
    input logic                 penable,
    input logic                 pwrite,
    input logic [31:0]          pwdata,
    input logic [31:0]          prdata,
    input logic                 pready,
    input logic                 pslverr,
    // Controls and detected codes
    input logic                 dcBlockEn,
    input acs_pkg::deemph_t     deemphSel,
    input acs_pkg::serial_fmt_t serialFormat,
    input logic                 shutdownAll,
    input acs_pkg::rate_code_t  sampleRate,
    input acs_pkg::ratio_code_t mclkRatio
);
    import acs_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    wire acc    = psel && penable;
    wire wrAcc  = acc && pwrite;
    wire mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h38};
    ////////////////////////
    a_unmapped_err: assert property (acc && !mapped |-> pslverr && pready)
        else $error("unmapped not refused");
    a_mapped_ok: assert property (pready == acc && !(acc && mapped && pslverr))
        else $error("bad mapped answer");
    a_fmt_store: assert property (wrAcc && paddr == 8'h10 |=> serialFormat == $past(pwdata[3:0]))
        else $error("format not stored");
    a_fmt_hold: assert property (!(wrAcc && paddr == 8'h10) |=> $stable(serialFormat))
        else $error("format moved");
    a_shut_store: assert property (wrAcc && paddr == 8'h14 |=> shutdownAll == $past(pwdata[6]))
        else $error("shutdown not stored");
    a_filter_store: assert property (wrAcc && paddr == 8'h0C |=> {dcBlockEn, deemphSel} ==
        {$past(pwdata[7]), $past(pwdata[1:0])}) else $error("filter not stored");
    a_rate_legal: assert property (!(sampleRate inside {3'b001, 3'b010}))
        else $error("reserved rate");
    a_ratio_legal: assert property (mclkRatio < 3'b110)
        else $error("reserved ratio");
    a_status_read: assert property (acc && !pwrite && paddr == 8'h00 |->
        prdata == {24'h00_0000, $past(sampleRate), $past(mclkRatio), 2'b00}) else $error("bad status read");
    a_read_upper: assert property (acc && !pwrite |-> prdata[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    cover property (wrAcc && paddr == 8'h10);
    cover property (acc && !mapped);
    cover property ($changed(mclkRatio));
endmodule

// ==== tb/audio_source_model.sv ====
// Serial audio source: master, bit and frame clocks from one phase count.
// Pins stand still while run is low.
`timescale 1ns/10ps
module audio_source_model (
    // Control from the bench
    input logic   run,
    input int     mclkPerFrame,
    input int     sclkPerFrame,
    // Clock pins
    output logic  mclkPin,
    output logic  sclkPin,
    output logic  lrclkPin
);
    int ph = 0;
    initial {mclkPin, sclkPin, lrclkPin} = 3'b000;
    // One count for all pins keeps ratios exact.
    always begin
        #40;
        if (run) begin
            ph = (ph + 1) % (2 * mclkPerFrame);
            mclkPin = ph[0];
            sclkPin = ((ph / (mclkPerFrame / sclkPerFrame)) % 2) != 0;
            lrclkPin = ph < mclkPerFrame;
        end
    end
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the clock status bank.
// Checker and source model compile first.
`timescale 1ns/10ps
module tb;
    import acs_pkg::*;
    localparam logic [6:0] REV = 7'h13;  // Arbitrary value.
    logic        sys_clk, resetn, psel, penable, pwrite, pready, pslverr, run;
    logic        pllUnlockPin, overCurrentPin, mclkPin, sclkPin, lrclkPin;
    logic        dcBlockEn, shutdownAll, clockMute, unmuteRamping;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [11:0] unmuteStep;
    deemph_t     deemphSel;
    serial_fmt_t serialFormat;
    rate_code_t  sampleRate;
    ratio_code_t mclkRatio;
    int          mclkPerFrame, sclkPerFrame, num_errors = 0, total_checks = 0;
    audio_clock_status_ctl #(.REVISION_CODE(REV)) DUT (.*);
    audio_source_model src (.*);
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    ////////////////////////
    task automatic give_verdict;
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int n = 0;
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            num_errors++;
            give_verdict();
        end
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(a, 1'b1, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic xe);
        logic [31:0] q;
        logic e;
        apb(a, 1'b0, 32'h0000_0000, q, e);
        chk(q, 32'(x));
        chk(32'(e), 32'(xe));
    endtask
    // Bounded poll; running out counts a mismatch and ends the run.
    task automatic poll(input logic [7:0] a, input logic [31:0] m, exp);
        logic [31:0] q;
        logic e;
        int n = 0;
        do begin
            repeat (500) @(posedge sys_clk);
            apb(a, 1'b0, 32'h0000_0000, q, e);
            n++;
        end while ((q & m) !== exp && n < 40);
        chk(q & m, exp);
        if ((q & m) !== exp) give_verdict();
    endtask
    ////////////////////////
    task automatic t_reset;
        logic [7:0] a [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h38, 8'h3C};
        logic [7:0] v [8] = '{8'h6C, {1'b0, REV}, 8'h00, 8'hA0, 8'h05, 8'h40, 8'h01, 8'h00};
        chk(32'({dcBlockEn, shutdownAll, serialFormat, deemphSel}), 32'h0000_00D4);
        for (int i = 0; i < 8; i++) rd(a[i], v[i], i == 7);
        $display("t_reset done");
    endtask
    task automatic t_ctrl;
        logic [7:0] c [4] = '{8'h00, 8'h82, 8'h23, 8'hA0};
        for (int f = 8; f >= 0; f--) begin
            wr(8'h10, 32'(f));
            rd(8'h10, 8'(f), 1'b0);
            chk(32'(serialFormat), 32'(f));
        end
        for (int i = 0; i < 4; i++) begin
            wr(8'h0C, 32'(c[i]));
            rd(8'h0C, c[i], 1'b0);
            chk(32'({dcBlockEn, deemphSel}), 32'({c[i][7], c[i][1:0]}));
        end
        wr(8'h14, 32'h0000_0000);
        chk(32'(shutdownAll), 32'h0000_0000);
        wr(8'h14, 32'h0000_0040);
        rd(8'h14, 8'h40, 1'b0);
        wr(8'h00, 32'h0000_0000);
        wr(8'h04, 32'h0000_0000);
        rd(8'h00, 8'h6C, 1'b0);
        rd(8'h04, {1'b0, REV}, 1'b0);
        $display("t_ctrl done");
    endtask
    task automatic t_faults;
        pllUnlockPin <= 1'b1;
        overCurrentPin <= 1'b1;
        repeat (5) @(posedge sys_clk);
        overCurrentPin <= 1'b0;
        repeat (4) @(posedge sys_clk);
        poll(8'h08, 32'h0000_00FF, 32'h0000_0042);
        wr(8'h08, 32'h0000_00FA);
        poll(8'h08, 32'h0000_00FF, 32'h0000_0042);
        wr(8'h08, 32'h0000_0000);
        poll(8'h08, 32'h0000_00FF, 32'h0000_0040);
        pllUnlockPin <= 1'b0;
        repeat (4) @(posedge sys_clk);
        wr(8'h08, 32'h0000_0000);
        poll(8'h08, 32'h0000_00FF, 32'h0000_0000);
        $display("t_faults done");
    endtask
    task automatic t_detect;
        run <= 1'b1;
        poll(8'h00, 32'h0000_00FF, 32'h0000_0010);
        wr(8'h08, 32'h0000_0000);
        poll(8'h08, 32'h0000_00FF, 32'h0000_0000);
        mclkPerFrame <= 256;
        poll(8'h00, 32'h0000_00FF, 32'h0000_006C);
        poll(8'h08, 32'h0000_0090, 32'h0000_0090);
        wr(8'h08, 32'h0000_0000);
        sclkPerFrame <= 32;
        poll(8'h08, 32'h0000_0020, 32'h0000_0020);
        $display("t_detect done");
    endtask
    initial begin
        {psel, penable, pwrite, pllUnlockPin, overCurrentPin, run, resetn} = '0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        mclkPerFrame = 384;
        sclkPerFrame = 64;
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        t_ctrl();
        t_faults();
        t_detect();
        give_verdict();
    end
endmodule
bind audio_clock_status_ctl acs_props u_props (.*);
